// [common/ria_defines.svh]
`ifndef RIA_DEFINES_SVH
`define RIA_DEFINES_SVH

// Register indices on the register port
`define RIA_IDX_FLAGS        2'h0
`define RIA_IDX_MASK         2'h1
`define RIA_IDX_CLKPOL       2'h2

// Event bit positions in the status and mask registers
`define RIA_BIT_SLEEP_ALERT  7
`define RIA_BIT_WAKEUP_ALERT 6
`define RIA_BIT_HALF_SYMBOL  5
`define RIA_BIT_KEY_REQUEST  4
`define RIA_BIT_RECEIVE_OK   3
`define RIA_BIT_SLOT_TWO     2
`define RIA_BIT_SLOT_ONE     1
`define RIA_BIT_NORMAL_TX    0

// Field positions in the sleep clock and polarity register
`define RIA_BIT_EDGE_POL     1
`define RIA_BIT_SLEEP_GATE   0

// Reset values
`define RIA_RST_FLAGS        8'h00
`define RIA_RST_MASK         8'hFF
`define RIA_RST_EDGE_POL     1'b0
`define RIA_RST_SLEEP_GATE   1'b0

`endif

// [common/ria_pkg.sv]
package ria_pkg;

    typedef logic [7:0] ria_byte_t;

    typedef enum logic [1:0] {
        RIA_REG_FLAGS,
        RIA_REG_MASK,
        RIA_REG_CLKPOL,
        RIA_REG_NONE
    } ria_reg_sel_t;

endpackage

// [logic/ria_event_latch.sv]
`timescale 1ns/1ps

module ria_event_latch #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] event_i,
    input  wire logic         clear_i,
    output logic      [W-1:0] flags_o,
    output logic      [W-1:0] flags_next_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } ria_latch_state_t;

    ria_latch_state_t s_q;
    ria_latch_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (clear_i) begin
            s_d.flags = '0;
        end
        s_d.flags = s_d.flags | event_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.flags <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags_o      = s_q.flags;
    assign flags_next_o = s_d.flags;

endmodule // ria_event_latch

// [logic/ria_top.sv]
// Function
// - One shared pin signals any enabled event
// - Status shows sources; read clears; reset zero
// - Mask bit one blocks pin; reset ones
// - Pin stays active until flags cleared or masked
// - Polarity bit one rising, zero falling, reset falling
// - Bits 7..4: sleep, wakeup, half-symbol, key
// - Bits 3..0: receive, slot two, slot one, tx
// - Bit 0 gates sleep clock; bit 1 polarity; bits 7..2 zero
// - Receive OK set when filtered packet stored
`timescale 1ns/1ps

`include "ria_defines.svh"

module ria_top
    import ria_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESETN_I,
    input  wire logic       SLEEP_ALERT_I,
    input  wire logic       WAKEUP_ALERT_I,
    input  wire logic       HALF_SYMBOL_TIMER_I,
    input  wire logic       KEY_REQUEST_I,
    input  wire logic       RECEIVE_OK_I,
    input  wire logic       SLOT_FIFO_TWO_RELEASE_I,
    input  wire logic       SLOT_FIFO_ONE_RELEASE_I,
    input  wire logic       NORMAL_TX_RELEASE_I,
    input  wire logic [1:0] REG_IDX_I,
    input  wire logic       REG_RD_I,
    input  wire logic       REG_WR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output logic      [7:0] REG_RDATA_O,
    output logic            REG_RVALID_O,
    output logic            INT_PIN_O,
    output logic            SLEEP_CLK_EN_O
);

    typedef struct packed {
        ria_byte_t interrupt_enable_mask;
        logic      pin_edge_polarity;
        logic      sleep_clock_gate;
        ria_byte_t rdata;
        logic      rvalid;
        logic      int_pin;
        logic      sleep_clk_en;
    } ria_top_state_t;

    ria_top_state_t s_q;
    ria_top_state_t s_d;

    logic [1:0]     rst_sync_q;
    logic           rst_n;
    ria_byte_t      event_vec;
    ria_byte_t      interrupt_flags;
    ria_byte_t      flags_next;
    logic           read_flags;

    // Decode a register index
    function automatic ria_reg_sel_t decode_idx(input logic [1:0] idx);
        ria_reg_sel_t sel;
        sel = RIA_REG_NONE;
        case (idx)
            `RIA_IDX_FLAGS: begin
                sel = RIA_REG_FLAGS;
            end
            `RIA_IDX_MASK: begin
                sel = RIA_REG_MASK;
            end
            `RIA_IDX_CLKPOL: begin
                sel = RIA_REG_CLKPOL;
            end
            default: begin
                sel = RIA_REG_NONE;
            end
        endcase
        return sel;
    endfunction

    // Pin level for a pending state and polarity
    function automatic logic pin_level(input logic pending, input logic rising);
        logic lvl;
        lvl = rising ? pending : ~pending;
        return lvl;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // Event vector in status bit order
    always_comb begin
        event_vec                            = 8'h00;
        event_vec[`RIA_BIT_SLEEP_ALERT]  = SLEEP_ALERT_I;
        event_vec[`RIA_BIT_WAKEUP_ALERT] = WAKEUP_ALERT_I;
        event_vec[`RIA_BIT_HALF_SYMBOL]  = HALF_SYMBOL_TIMER_I;
        event_vec[`RIA_BIT_KEY_REQUEST]  = KEY_REQUEST_I;
        event_vec[`RIA_BIT_RECEIVE_OK]   = RECEIVE_OK_I;
        event_vec[`RIA_BIT_SLOT_TWO]     = SLOT_FIFO_TWO_RELEASE_I;
        event_vec[`RIA_BIT_SLOT_ONE]     = SLOT_FIFO_ONE_RELEASE_I;
        event_vec[`RIA_BIT_NORMAL_TX]    = NORMAL_TX_RELEASE_I;
    end

    assign read_flags = REG_RD_I && (decode_idx(REG_IDX_I) == RIA_REG_FLAGS);

    // Flags latch regardless of mask; set wins over read-clear
    ria_event_latch #(
        .W (8)
    ) u_flags (
        .clk_i        (CORE_CLK_I),
        .rst_n_i      (rst_n),
        .event_i      (event_vec),
        .clear_i      (read_flags),
        .flags_o      (interrupt_flags),
        .flags_next_o (flags_next)
    );

    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        if (REG_WR_I) begin
            case (decode_idx(REG_IDX_I))
                RIA_REG_MASK: begin
                    s_d.interrupt_enable_mask = REG_WDATA_I;
                end
                RIA_REG_CLKPOL: begin
                    s_d.pin_edge_polarity = REG_WDATA_I[`RIA_BIT_EDGE_POL];
                    s_d.sleep_clock_gate  = REG_WDATA_I[`RIA_BIT_SLEEP_GATE];
                end
                default: begin
                    s_d.rvalid = 1'b0;
                end
            endcase
        end
        if (REG_RD_I) begin
            s_d.rvalid = 1'b1;
            case (decode_idx(REG_IDX_I))
                RIA_REG_FLAGS: begin
                    s_d.rdata = interrupt_flags;
                end
                RIA_REG_MASK: begin
                    s_d.rdata = s_q.interrupt_enable_mask;
                end
                RIA_REG_CLKPOL: begin
                    s_d.rdata = 8'h00;
                    s_d.rdata[`RIA_BIT_EDGE_POL]   = s_q.pin_edge_polarity;
                    s_d.rdata[`RIA_BIT_SLEEP_GATE] = s_q.sleep_clock_gate;
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
        // One pin for all sources, held while any unmasked flag stands
        s_d.int_pin = pin_level(|(flags_next & ~s_d.interrupt_enable_mask),
                                s_d.pin_edge_polarity);
        s_d.sleep_clk_en = ~s_d.sleep_clock_gate;
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_q.interrupt_enable_mask <= `RIA_RST_MASK;
            s_q.pin_edge_polarity     <= `RIA_RST_EDGE_POL;
            s_q.sleep_clock_gate      <= `RIA_RST_SLEEP_GATE;
            s_q.rdata                 <= 8'h00;
            s_q.rvalid                <= 1'b0;
            s_q.int_pin               <= 1'b1;
            s_q.sleep_clk_en          <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign REG_RDATA_O    = s_q.rdata;
    assign REG_RVALID_O   = s_q.rvalid;
    assign INT_PIN_O      = s_q.int_pin;
    assign SLEEP_CLK_EN_O = s_q.sleep_clk_en;

endmodule // ria_top

// [dv/ria_chk.sv]
`timescale 1ns/1ps
module ria_chk (
    input wire logic       CORE_CLK_I, RESETN_I, REG_RD_I, REG_WR_I, REG_RVALID_O,
    input wire logic       INT_PIN_O, SLEEP_CLK_EN_O, SLEEP_ALERT_I, WAKEUP_ALERT_I,
    input wire logic       HALF_SYMBOL_TIMER_I, KEY_REQUEST_I, RECEIVE_OK_I,
    input wire logic       SLOT_FIFO_TWO_RELEASE_I, SLOT_FIFO_ONE_RELEASE_I,
    input wire logic       NORMAL_TX_RELEASE_I,
    input wire logic [1:0] REG_IDX_I,
    input wire logic [7:0] REG_WDATA_I, REG_RDATA_O
);
    logic [7:0] ev, msk_q;
    logic       pol_q;
    assign ev = {SLEEP_ALERT_I, WAKEUP_ALERT_I, HALF_SYMBOL_TIMER_I, KEY_REQUEST_I,
                 RECEIVE_OK_I, SLOT_FIFO_TWO_RELEASE_I, SLOT_FIFO_ONE_RELEASE_I,
                 NORMAL_TX_RELEASE_I};
    // Shadow of mask and polarity
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            msk_q <= 8'hFF;
            pol_q <= 1'b0;
        end else if (REG_WR_I && REG_IDX_I == 2'h1) begin
            msk_q <= REG_WDATA_I;
        end else if (REG_WR_I && REG_IDX_I == 2'h2) begin
            pol_q <= REG_WDATA_I[1];
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    AST_RVALID: assert property (REG_RD_I |=> REG_RVALID_O)
        else $error("read not answered");
    AST_RVALID_ONE: assert property (REG_RVALID_O |-> $past(REG_RD_I))
        else $error("answer without read");
    AST_IDX3: assert property (REG_RD_I && REG_IDX_I == 2'h3 |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    AST_CLEAR: assert property (REG_RD_I && REG_IDX_I == 2'h0 ##1 !REG_RD_I ##1
        REG_RD_I && REG_IDX_I == 2'h0 |=> REG_RDATA_O == ($past(ev, 2) | $past(ev, 3)))
        else $error("flags not cleared by read");
    AST_SLEEP: assert property (REG_WR_I && REG_IDX_I == 2'h2 |=>
        SLEEP_CLK_EN_O == !$past(REG_WDATA_I[0])) else $error("sleep clock gate wrong");
    AST_MASKALL: assert property (REG_WR_I && REG_IDX_I == 2'h1 && REG_WDATA_I == 8'hFF
        |=> INT_PIN_O == !pol_q) else $error("pin active while all masked");
    AST_ACTIVE: assert property ((ev & ~msk_q) != 8'h00 && !REG_WR_I
        |=> INT_PIN_O == pol_q) else $error("enabled event did not raise pin");
    AST_STAY: assert property (!REG_RD_I && !REG_WR_I && INT_PIN_O == pol_q
        |=> INT_PIN_O == pol_q) else $error("pin dropped without clear");
endmodule // ria_chk
bind ria_top ria_chk chk_u (.*);

// [dv/ria_evt_mdl.sv]
`timescale 1ns/1ps
// Event sources: raise each requested event one cycle later, for as long as it is requested
module ria_evt_mdl (
    input  wire logic       clk_i,
    input  wire logic [7:0] req_i,
    output logic      [7:0] ev_o = 8'h00
);
    always @(posedge clk_i) ev_o <= req_i;
endmodule // ria_evt_mdl

// [dv/ria_top_tb_top.sv]
`timescale 1ns/1ps
module ria_top_tb_top;
    logic       clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, rv, pin, slp;
    logic [1:0] idx = 2'h0;
    logic [7:0] wd = 8'h00, req = 8'h00, ev, rdat;
    int         miscompares = 0, tests_run = 0;
    ria_evt_mdl evt_u (.clk_i(clk), .req_i(req), .ev_o(ev));
    ria_top dut_u (.CORE_CLK_I(clk), .RESETN_I(rst_n), .SLEEP_ALERT_I(ev[7]),
        .WAKEUP_ALERT_I(ev[6]), .HALF_SYMBOL_TIMER_I(ev[5]), .KEY_REQUEST_I(ev[4]),
        .RECEIVE_OK_I(ev[3]), .SLOT_FIFO_TWO_RELEASE_I(ev[2]),
        .SLOT_FIFO_ONE_RELEASE_I(ev[1]), .NORMAL_TX_RELEASE_I(ev[0]), .REG_IDX_I(idx),
        .REG_RD_I(rd), .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RDATA_O(rdat),
        .REG_RVALID_O(rv), .INT_PIN_O(pin), .SLEEP_CLK_EN_O(slp));
    initial begin
        forever #10 clk = ~clk;
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task rd_reg(input logic [1:0] i, input logic [7:0] e);
        @(posedge clk) #1 rd = 1'b1;
        idx = i;
        @(posedge clk) #1 rd = 1'b0;
        chk(8'(rv), 8'h01);
        chk(rdat, e);
    endtask
    task wr_reg(input logic [1:0] i, input logic [7:0] d);
        @(posedge clk) #1 wr = 1'b1;
        idx = i;
        wd = d;
        @(posedge clk) #1 wr = 1'b0;
    endtask
    task evt(input logic [7:0] v);
        @(posedge clk) #1 req = v;
        @(posedge clk) #1 req = 8'h00;
        @(posedge clk) #1;
    endtask
    task give_verdict;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(8'(pin), 8'h01);
        chk(8'(slp), 8'h01);
        rd_reg(2'h0, 8'h00);
        rd_reg(2'h1, 8'hFF);
        rd_reg(2'h2, 8'h00);
        rd_reg(2'h3, 8'h00);
        for (int i = 0; i < 8; i++) begin
            evt(8'h01 << i);
            chk(8'(pin), 8'h01);
            rd_reg(2'h0, 8'h01 << i);
        end
        rd_reg(2'h0, 8'h00);
        wr_reg(2'h2, 8'hFF);
        rd_reg(2'h2, 8'h03);
        chk(8'(slp), 8'h00);
        chk(8'(pin), 8'h00);
        wr_reg(2'h1, 8'hF7);
        evt(8'h08);
        chk(8'(pin), 8'h01);
        repeat (5) @(posedge clk);
        #1;
        chk(8'(pin), 8'h01);
        wr_reg(2'h1, 8'hFF);
        chk(8'(pin), 8'h00);
        wr_reg(2'h1, 8'hF7);
        chk(8'(pin), 8'h01);
        wr_reg(2'h0, 8'hFF);
        rd_reg(2'h0, 8'h08);
        chk(8'(pin), 8'h00);
        // Event reaches the flags at the same edge as the read-clear
        fork
            rd_reg(2'h0, 8'h00);
            begin
                req = 8'h01;
                @(posedge clk) #1 req = 8'h00;
            end
        join
        rd_reg(2'h0, 8'h01);
        wr_reg(2'h2, 8'h00);
        chk(8'(slp), 8'h01);
        give_verdict();
    end
endmodule // ria_top_tb_top
